// *** shared/charge_supervisor_regs.vh ***
// Register map, field positions, reset values and timing counts
`ifndef CHARGE_SUPERVISOR_REGS_VH
`define CHARGE_SUPERVISOR_REGS_VH

// ****************************************************
// Register offsets (byte addresses)
// ****************************************************
`define CTRL_OFFSET 12'h000
`define CFG_OFFSET 12'h004
`define STATUS_OFFSET 12'h008
`define FAULT_OFFSET 12'h00C
`define TIMER_OFFSET 12'h010

// ****************************************************
// Control register fields
// ****************************************************
`define CTRL_CHARGE_ALLOW_BIT 0
`define CTRL_SAFETY_TIMER_ON_BIT 1
`define CTRL_LONG_TIMER_SELECT_BIT 2
`define CTRL_SLOW_COUNT_ON_BIT 3
`define CTRL_TEMP_LIMIT_ON_BIT 4
`define CTRL_WARM_VOLTAGE_SELECT_BIT 5
`define CTRL_COOL_CURRENT_SELECT_BIT 6
`define CTRL_RESTART_BIT 7
`define CTRL_RESET 8'h1F

// ****************************************************
// Config register fields
// ****************************************************
`define CFG_MIN_SYS_LSB 0
`define CFG_MIN_SYS_RESET 3'h5

// ****************************************************
// Fault and state codes
// ****************************************************
`define CHG_FAULT_NONE 2'h0
`define CHG_FAULT_TIMER 2'h3
`define THERM_CODE_NORMAL 3'h0
`define THERM_CODE_BOOST_COLD 3'h5
`define THERM_CODE_BOOST_HOT 3'h6
`define SRC_STATE_OFF 3'h0

// ****************************************************
// Timing
// ****************************************************
`define CLK_HZ 20000000
`define TICK_SECONDS 1
`define TICK_CYCLES (`CLK_HZ * `TICK_SECONDS)
`define ALERT_US 256
`define ALERT_CYCLES ((`ALERT_US * 20) / 1)
`define LIMIT_SHORT_HOURS 2
`define LIMIT_MID_HOURS 4
`define LIMIT_LONG_HOURS 6
`define SECONDS_PER_HOUR 3600

`endif

// *** src/charge_supervisor.v ***
// Charge temperature, safety timer and status supervisor
// Operation
// - New charge cycle starts only with thermistor inside coldest-to-hottest window.
// - Leaving window while charging forces zero current until it returns.
// - Warm zone picks normal or lower voltage target by warm_voltage_select.
// - Cool zone scales charge current to one of two fractions.
// - A control bit disables temperature charge limiting completely.
// - Boost outside its window suspends boost, zeros source state, loads fault.
// - Boost back inside window resumes and clears thermistor fault code.
// - Timer expiry stops charging, sets timer fault, pulses host_alert_n.
// - Short limit below low battery threshold, longer limit above it.
// - Clearing safety_timer_on disables timer expiry entirely.
// - Clearing long_timer_select shortens the longer limit to middle value.
// - Timer runs half rate during input limits, cool zone, thermal regulation.
// - Clearing slow_count_on forces full-rate counting.
// - Timer holds count while a fault suspends charging.
// - Timer clears on restart or toggling charge_enable_n or charge_allow.
// - min_sys_voltage_sel field exists with a defined reset default.
// - min_sys_reg_flag follows minimum system voltage regulation.
// - Input current and voltage limiting flags reported independently.
// - Battery below depletion turns battery_switch off, leaves supplement mode.
// - Each host alert is one fixed-length active-low pulse.
// - Top-off timer pauses and slows together with the safety timer.
`timescale 1ns/1ps
`default_nettype none
`include "charge_supervisor_regs.vh"

module charge_supervisor #(
    parameter TICK_CYCLES = `TICK_CYCLES,
    parameter ALERT_CYCLES = `ALERT_CYCLES,
    parameter SEC_PER_HOUR = `SECONDS_PER_HOUR,
    parameter TOPOFF_TICKS = 900
) (
    input wire mclk_in,
    input wire rst_n_in,
    input wire clk_en_in,
    // APB slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    output wire [31:0] prdata_out,
    output wire pready_out,
    output wire pslverr_out,
    // Analog comparator flags, asynchronous
    input wire ts_in_window_in,
    input wire ts_cool_in,
    input wire ts_warm_in,
    input wire ts_boost_cold_in,
    input wire ts_boost_hot_in,
    input wire vbat_above_low_in,
    input wire vbat_below_full_in,
    input wire vbat_depleted_in,
    input wire in_current_limit_in,
    input wire in_voltage_limit_in,
    input wire thermal_reg_in,
    input wire min_sys_reg_in,
    input wire charge_enable_n_in,
    input wire boost_request_in,
    input wire terminated_in,
    input wire [2:0] source_state_in,
    // Outputs
    output reg charging_out,
    output reg zero_current_out,
    output reg warm_voltage_low_out,
    output reg [1:0] current_scale_out,
    output reg boosting_out,
    output reg [2:0] input_source_state_out,
    output reg battery_switch_out,
    output reg topoff_active_out,
    output reg host_alert_n_out
);

    // ****************************************************
    // Reset release
    // ****************************************************
    reg [1:0] rst_sync_reg;
    wire rst_n = rst_sync_reg[1];

    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    // ****************************************************
    // Comparator synchronizers, three stages
    // ****************************************************
    localparam NSYNC = 13;
    wire ts_window_dummy = ts_in_window_in;
    wire [NSYNC-1:0] raw_in = {charge_enable_n_in, min_sys_reg_in,
        thermal_reg_in, in_voltage_limit_in, in_current_limit_in,
        vbat_depleted_in, vbat_below_full_in, vbat_above_low_in,
        ts_boost_hot_in, ts_boost_cold_in, ts_warm_in, ts_cool_in,
        ts_window_dummy};
    reg [NSYNC-1:0] s1_reg, s2_reg, s3_reg, flt_reg;

    // Change accepted once stages two and three agree
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= {NSYNC{1'b0}};
            s2_reg <= {NSYNC{1'b0}};
            s3_reg <= {NSYNC{1'b0}};
            flt_reg <= {NSYNC{1'b0}};
        end else if (clk_en_in) begin
            s1_reg <= raw_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            flt_reg <= (s2_reg & s3_reg) | (flt_reg & (s2_reg | s3_reg));
        end
    end

    wire in_window = flt_reg[0];
    wire cool = flt_reg[1];
    wire warm = flt_reg[2];
    wire boost_cold = flt_reg[3];
    wire boost_hot = flt_reg[4];
    wire vbat_above_low = flt_reg[5];
    wire vbat_below_full = flt_reg[6];
    wire vbat_depleted = flt_reg[7];
    wire in_cur_lim = flt_reg[8];
    wire in_volt_lim = flt_reg[9];
    wire thermal_reg = flt_reg[10];
    wire min_sys_reg = flt_reg[11];
    wire ce_n = flt_reg[12];

    // ****************************************************
    // Registers
    // ****************************************************
    reg [7:0] ctrl_reg;
    reg [2:0] min_sys_voltage_sel_reg;
    reg [1:0] charge_fault_code_reg;
    reg [2:0] thermistor_fault_code_reg;
    reg [31:0] prdata_reg;
    reg restart_reg;

    wire charge_allow = ctrl_reg[`CTRL_CHARGE_ALLOW_BIT];
    wire safety_timer_on = ctrl_reg[`CTRL_SAFETY_TIMER_ON_BIT];
    wire long_timer_select = ctrl_reg[`CTRL_LONG_TIMER_SELECT_BIT];
    wire slow_count_on = ctrl_reg[`CTRL_SLOW_COUNT_ON_BIT];
    wire temp_limit_on = ctrl_reg[`CTRL_TEMP_LIMIT_ON_BIT];
    wire warm_voltage_select = ctrl_reg[`CTRL_WARM_VOLTAGE_SELECT_BIT];
    wire cool_current_select = ctrl_reg[`CTRL_COOL_CURRENT_SELECT_BIT];

    wire wr_en = psel_in & penable_in & pwrite_in & clk_en_in;
    wire rd_setup = psel_in & ~penable_in & ~pwrite_in & clk_en_in;
    wire mapped = (paddr_in == `CTRL_OFFSET) | (paddr_in == `CFG_OFFSET) |
        (paddr_in == `STATUS_OFFSET) | (paddr_in == `FAULT_OFFSET) |
        (paddr_in == `TIMER_OFFSET);

    // Zero wait states; unmapped addresses answer with an error
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~mapped;
    assign prdata_out = prdata_reg;

    // ****************************************************
    // Safety timer state
    // ****************************************************
    reg [31:0] presc_reg;
    reg half_reg;
    reg [15:0] secs_reg;
    reg [15:0] topoff_reg;
    reg ce_n_d_reg, allow_d_reg, term_d_reg;
    reg timer_fault_reg;

    wire tick = (presc_reg == TICK_CYCLES - 1);
    wire temp_ok = ~temp_limit_on | in_window;
    // Suspended while thermistor out of window or fault active
    wire susp = (temp_limit_on & ~in_window) | timer_fault_reg;
    wire enabled = charge_allow & ~ce_n & ~boost_request_in;
    wire slow = slow_count_on & (in_cur_lim | in_volt_lim |
        (temp_limit_on & cool) | thermal_reg);
    wire advance = tick & (~slow | half_reg);
    wire toggled = (ce_n != ce_n_d_reg) | (charge_allow != allow_d_reg) |
        restart_reg;
    wire [31:0] limit_hours = ~vbat_above_low ? `LIMIT_SHORT_HOURS :
        (long_timer_select ? `LIMIT_LONG_HOURS : `LIMIT_MID_HOURS);
    wire [31:0] limit_secs = limit_hours * SEC_PER_HOUR;
    wire expire = safety_timer_on & charging_out &
        ({16'h0000, secs_reg} >= limit_secs);

    // Prescaler and timer counters
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            presc_reg <= 32'h00000000;
            half_reg <= 1'b0;
            secs_reg <= 16'h0000;
            topoff_reg <= 16'h0000;
            ce_n_d_reg <= 1'b1;
            allow_d_reg <= 1'b0;
            term_d_reg <= 1'b0;
        end else if (clk_en_in) begin
            ce_n_d_reg <= ce_n;
            allow_d_reg <= charge_allow;
            term_d_reg <= terminated_in;
            presc_reg <= tick ? 32'h00000000 : presc_reg + 32'h00000001;
            if (tick & slow)
                half_reg <= ~half_reg;
            if (toggled) begin
                secs_reg <= 16'h0000;
                half_reg <= 1'b0;
            end else if (charging_out & ~susp & advance) begin
                secs_reg <= secs_reg + 16'h0001;
            end
            // Top-off shares suspend and slow of the safety timer
            if (toggled | (terminated_in & ~term_d_reg))
                topoff_reg <= 16'h0000;
            else if (topoff_active_out & ~susp & advance)
                topoff_reg <= topoff_reg + 16'h0001;
        end
    end

    // ****************************************************
    // Charge, boost and switch control
    // ****************************************************
    reg [15:0] alert_cnt_reg;
    reg alert_req;

    always @* begin
        alert_req = 1'b0;
        if (expire & ~timer_fault_reg)
            alert_req = 1'b1;
        if (boosting_out & (boost_cold | boost_hot))
            alert_req = 1'b1;
    end

    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            charging_out <= 1'b0;
            zero_current_out <= 1'b1;
            warm_voltage_low_out <= 1'b0;
            current_scale_out <= 2'h0;
            boosting_out <= 1'b0;
            input_source_state_out <= `SRC_STATE_OFF;
            battery_switch_out <= 1'b1;
            topoff_active_out <= 1'b0;
            timer_fault_reg <= 1'b0;
            charge_fault_code_reg <= `CHG_FAULT_NONE;
            thermistor_fault_code_reg <= `THERM_CODE_NORMAL;
        end else if (clk_en_in) begin
            if (toggled) begin
                timer_fault_reg <= 1'b0;
                charge_fault_code_reg <= `CHG_FAULT_NONE;
            end
            if (expire) begin
                timer_fault_reg <= 1'b1;
                charge_fault_code_reg <= `CHG_FAULT_TIMER;
                charging_out <= 1'b0;
            end else if (~enabled) begin
                charging_out <= 1'b0;
            end else if (~charging_out & temp_ok & vbat_below_full &
                    ~timer_fault_reg & ~toggled) begin
                charging_out <= 1'b1;
            end
            zero_current_out <= ~charging_out | susp;
            warm_voltage_low_out <= temp_limit_on & warm &
                warm_voltage_select;
            // 0 full, 1 half, 2 one fifth
            current_scale_out <= (temp_limit_on & cool) ?
                (cool_current_select ? 2'h2 : 2'h1) : 2'h0;
            topoff_active_out <= charging_out & terminated_in &
                (topoff_reg < TOPOFF_TICKS);
            // Boost window check
            if (boost_request_in & (boost_cold | boost_hot)) begin
                boosting_out <= 1'b0;
                input_source_state_out <= `SRC_STATE_OFF;
                thermistor_fault_code_reg <= boost_cold ?
                    `THERM_CODE_BOOST_COLD : `THERM_CODE_BOOST_HOT;
            end else begin
                boosting_out <= boost_request_in;
                input_source_state_out <= source_state_in;
                thermistor_fault_code_reg <= `THERM_CODE_NORMAL;
            end
            // Depleted battery drops out of supplement mode
            battery_switch_out <= ~vbat_depleted;
        end
    end

    // ****************************************************
    // Host alert pulse
    // ****************************************************
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            alert_cnt_reg <= 16'h0000;
            host_alert_n_out <= 1'b1;
        end else if (clk_en_in) begin
            // New request during a pulse is merged, pulse not stretched
            if (alert_cnt_reg != 16'h0000) begin
                alert_cnt_reg <= alert_cnt_reg - 16'h0001;
                host_alert_n_out <= (alert_cnt_reg == 16'h0001);
            end else if (alert_req & host_alert_n_out) begin
                alert_cnt_reg <= ALERT_CYCLES[15:0];
                host_alert_n_out <= 1'b0;
            end
        end
    end

    // ****************************************************
    // APB register access
    // ****************************************************
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `CTRL_RESET;
            min_sys_voltage_sel_reg <= `CFG_MIN_SYS_RESET;
            restart_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else if (clk_en_in) begin
            restart_reg <= 1'b0;
            if (wr_en & (paddr_in == `CTRL_OFFSET)) begin
                ctrl_reg <= {1'b0, pwdata_in[6:0]};
                restart_reg <= pwdata_in[`CTRL_RESTART_BIT];
            end
            if (wr_en & (paddr_in == `CFG_OFFSET))
                min_sys_voltage_sel_reg <= pwdata_in[2:0];
            if (rd_setup) begin
                case (paddr_in)
                    `CTRL_OFFSET: prdata_reg <= {24'h000000, ctrl_reg};
                    `CFG_OFFSET:
                        prdata_reg <= {29'h0, min_sys_voltage_sel_reg};
                    // Status flags
                    `STATUS_OFFSET: prdata_reg <= {24'h000000,
                        topoff_active_out, battery_switch_out,
                        boosting_out, charging_out, in_window,
                        in_volt_lim, in_cur_lim, min_sys_reg};
                    `FAULT_OFFSET: prdata_reg <= {27'h0,
                        thermistor_fault_code_reg, charge_fault_code_reg};
                    `TIMER_OFFSET: prdata_reg <= {topoff_reg, secs_reg};
                    default: prdata_reg <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // charge_supervisor
`default_nettype wire

// *** tb/thermistor_comparator_model.sv ***
// Thermistor comparator bank model driven by a temperature zone code
`timescale 1ns/1ps
`default_nettype none
module thermistor_comparator_model (
    input wire logic [2:0] zone_in,
    output logic ts_in_window_out,
    output logic ts_cool_out,
    output logic ts_warm_out,
    output logic ts_boost_cold_out,
    output logic ts_boost_hot_out
);
    // Zones: 0 normal, 1 cool, 2 warm, 3 too cold, 4 too hot,
    // 5 boost cold, 6 boost hot; boost zones lie outside the charge window
    assign ts_in_window_out = (zone_in <= 3'h2);
    assign ts_cool_out = (zone_in == 3'h1);
    assign ts_warm_out = (zone_in == 3'h2);
    assign ts_boost_cold_out = (zone_in == 3'h5);
    assign ts_boost_hot_out = (zone_in == 3'h6);
endmodule // thermistor_comparator_model
`default_nettype wire

// *** tb/charge_supervisor_chk.sv ***
// Port-level assertion checker for the charge supervisor
`timescale 1ns/1ps
`default_nettype none
module charge_supervisor_chk #(
    parameter ALERT_CYCLES = 8
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic ts_in_window_in,
    input wire logic ts_boost_cold_in,
    input wire logic ts_boost_hot_in,
    input wire logic vbat_depleted_in,
    input wire logic charging_out,
    input wire logic zero_current_out,
    input wire logic boosting_out,
    input wire logic [2:0] input_source_state_out,
    input wire logic battery_switch_out,
    input wire logic host_alert_n_out
);
    // ****************************************************
    // Alert width counter
    // ****************************************************
    int low_cnt;
    // Counts low cycles of the alert line, cleared while it is high
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_cnt <= 0;
        end else if (!host_alert_n_out) begin
            low_cnt <= low_cnt + 1;
        end else begin
            low_cnt <= 0;
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // ****************************************************
    // Properties
    // ****************************************************
    property p_alert_len; $rose(host_alert_n_out) |-> low_cnt == ALERT_CYCLES; endproperty
    a_alert_len: assert property (p_alert_len) else $error("alert too short");
    property p_alert_max; !host_alert_n_out |-> low_cnt < ALERT_CYCLES; endproperty
    a_alert_max: assert property (p_alert_max) else $error("alert too long");
    property p_ready; psel_in && penable_in |-> pready_out; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_slverr; pslverr_out |-> psel_in && penable_in; endproperty
    a_slverr: assert property (p_slverr) else $error("stray pslverr");
    property p_suspend;
        charging_out && $fell(ts_in_window_in) |-> ##[1:8] zero_current_out;
    endproperty
    a_suspend: assert property (p_suspend) else $error("no suspend");
    property p_window;
        (!ts_in_window_in)[*8] |-> !charging_out || zero_current_out;
    endproperty
    a_window: assert property (p_window) else $error("charge off window");
    property p_boost;
        boosting_out && ($rose(ts_boost_cold_in) || $rose(ts_boost_hot_in))
            |-> ##[1:8] (!boosting_out && input_source_state_out == 3'h0);
    endproperty
    a_boost: assert property (p_boost) else $error("boost not stopped");
    property p_deplete; $rose(vbat_depleted_in) |-> ##[1:8] !battery_switch_out; endproperty
    a_deplete: assert property (p_deplete) else $error("switch stays on");
endmodule // charge_supervisor_chk
bind charge_supervisor charge_supervisor_chk #(.ALERT_CYCLES(ALERT_CYCLES))
    i_charge_supervisor_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .ts_in_window_in(ts_in_window_in),
    .ts_boost_cold_in(ts_boost_cold_in), .ts_boost_hot_in(ts_boost_hot_in),
    .vbat_depleted_in(vbat_depleted_in), .charging_out(charging_out),
    .zero_current_out(zero_current_out), .boosting_out(boosting_out),
    .input_source_state_out(input_source_state_out),
    .battery_switch_out(battery_switch_out),
    .host_alert_n_out(host_alert_n_out));
`default_nettype wire

// *** tb/tb_charge_temp_timer_supervisor.sv ***
// Self-checking testbench for the charge supervisor
`timescale 1ns/1ps
`default_nettype none
`include "charge_supervisor_regs.vh"
module tb_charge_temp_timer_supervisor;
    localparam int TICK = 16;
    localparam int SPH = 4;
    logic mclk_in = 0, rst_n_in = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [2:0] zone = 3'h0, src = 3'h2, in_src;
    logic above_low = 0, depleted = 0, cur_lim = 0, volt_lim = 0;
    logic min_sys = 0, chg_en_n = 1, boost_req = 0, pready, pslverr;
    logic term = 0, topoff;
    logic win, cool, warm, bcold, bhot, charging, zero_cur, warm_low;
    logic boosting, bat_sw, alert_n, s0w, s1w;
    logic [1:0] scale, s0, s1;
    logic [64:0] notes[$];
    int miscompares = 0, checked = 0, cycles = 0;
    thermistor_comparator_model i_thermistor_comparator_model (
        .zone_in(zone), .ts_in_window_out(win), .ts_cool_out(cool),
        .ts_warm_out(warm), .ts_boost_cold_out(bcold), .ts_boost_hot_out(bhot));
    charge_supervisor #(.TICK_CYCLES(TICK), .SEC_PER_HOUR(SPH),
        .ALERT_CYCLES(8), .TOPOFF_TICKS(4)) i_charge_supervisor (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .ts_in_window_in(win),
        .ts_cool_in(cool), .ts_warm_in(warm), .ts_boost_cold_in(bcold),
        .ts_boost_hot_in(bhot), .vbat_above_low_in(above_low),
        .vbat_below_full_in(1'b1), .vbat_depleted_in(depleted),
        .in_current_limit_in(cur_lim), .in_voltage_limit_in(volt_lim),
        .thermal_reg_in(1'b0), .min_sys_reg_in(min_sys),
        .charge_enable_n_in(chg_en_n), .boost_request_in(boost_req),
        .terminated_in(term), .source_state_in(src), .charging_out(charging),
        .zero_current_out(zero_cur), .warm_voltage_low_out(warm_low),
        .current_scale_out(scale), .boosting_out(boosting),
        .input_source_state_out(in_src), .battery_switch_out(bat_sw),
        .topoff_active_out(topoff), .host_alert_n_out(alert_n));
    // ****************************************************
    // Clock, timeout and reporting
    // ****************************************************
    always #25 mclk_in = ~mclk_in;
    // A hang counts as a mismatch and still reaches the verdict
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (miscompares == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, exp, input string what);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s %h vs %h", $time, what, got, exp);
        end
    endtask
    // Read results are matched against the oldest note
    always @(posedge mclk_in) begin
        if (psel && penable && pready && !pwrite && notes.size() > 0) begin
            cmp({31'h0, pslverr}, {31'h0, notes[0][64]}, "slverr");
            cmp(prdata & notes[0][63:32], notes[0][31:0], "read data");
            void'(notes.pop_front());
        end
    end
    // ****************************************************
    // APB master and scenario tasks
    // ****************************************************
    // Holds the request until pready is seen at an access edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, m, input logic e);
        @(posedge mclk_in);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : 32'h0;
        if (!w) notes.push_back({e, m, d & m});
        @(posedge mclk_in);
        penable <= 1;
        @(posedge mclk_in);
        while (pready !== 1'b1) @(posedge mclk_in);
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, m);
        apb(1'b0, a, d, m, 1'b0);
    endtask
    // Restart, optionally leave the window for gap cycles, time the alert
    task automatic timer_run(input logic [7:0] ctrl, input logic hi_bat,
            input logic lim, input int hrs, input int gap);
        int t;
        int exp_c;
        above_low <= hi_bat;
        cur_lim <= lim;
        repeat (16) @(posedge mclk_in);
        wr(`CTRL_OFFSET, {24'h0, ctrl | 8'h80});
        exp_c = (hrs == 0) ? 800 : hrs * SPH * TICK + gap;
        t = 0;
        while (alert_n !== 1'b0 && t < 800) begin
            if (t == 40 && gap > 0) zone <= 3'h3;
            else if (t == 40 + gap) zone <= 3'h0;
            t++;
            @(posedge mclk_in);
        end
        cmp(32'(t > exp_c - 2 * TICK && t < exp_c + 2 * TICK), 1, "limit");
        if (hrs > 0) begin
            repeat (2) @(posedge mclk_in);
            cmp({31'h0, charging}, 0, "charging");
            rd(`FAULT_OFFSET, {30'h0, `CHG_FAULT_TIMER}, 32'h3);
        end
    endtask
    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        void'($urandom(74));
        repeat (3) @(posedge mclk_in);
        rst_n_in <= 1;
        repeat (3) @(posedge mclk_in);
        rd(`CTRL_OFFSET, 32'h1F, 32'h7F);
        rd(`CFG_OFFSET, {29'h0, `CFG_MIN_SYS_RESET}, 32'h7);
        apb(1'b0, 12'h014, 32'h0, 32'hFFFFFFFF, 1'b1);
        s0 = 2'($urandom % 8);
        src <= 3'($urandom % 7 + 1);
        wr(`CFG_OFFSET, {30'h0, s0});
        rd(`CFG_OFFSET, {30'h0, s0}, 32'h7);
        // Every combination of the three status comparators
        for (int i = 0; i < 8; i++) begin
            {volt_lim, cur_lim, min_sys} <= 3'(i);
            repeat (8) @(posedge mclk_in);
            rd(`STATUS_OFFSET, i, 32'h7);
        end
        {volt_lim, cur_lim, min_sys} <= 3'h0;
        chg_en_n <= 0;
        zone <= 3'h1;
        repeat (8) @(posedge mclk_in);
        cmp({31'h0, charging}, 1, "charging");
        s0 = scale;
        wr(`CTRL_OFFSET, 32'h5F);
        repeat (8) @(posedge mclk_in);
        s1 = scale;
        cmp({28'h0, s0, s1}, 32'h6, "cool scale");
        wr(`CTRL_OFFSET, 32'h0F);
        repeat (8) @(posedge mclk_in);
        cmp({30'h0, scale}, 0, "scale off");
        zone <= 3'h2;
        wr(`CTRL_OFFSET, 32'h1F);
        repeat (8) @(posedge mclk_in);
        s0w = warm_low;
        wr(`CTRL_OFFSET, 32'h3F);
        repeat (8) @(posedge mclk_in);
        s1w = warm_low;
        cmp({30'h0, s0w, s1w}, 32'h1, "warm target");
        zone <= 3'h0;
        timer_run(8'h1F, 1'b0, 1'b0, 2, 0);
        timer_run(8'h1F, 1'b1, 1'b0, 6, 0);
        timer_run(8'h1B, 1'b1, 1'b0, 4, 0);
        timer_run(8'h1B, 1'b1, 1'b1, 8, 0);
        timer_run(8'h13, 1'b1, 1'b1, 4, 0);
        timer_run(8'h1B, 1'b1, 1'b0, 4, 100);
        timer_run(8'h1D, 1'b1, 1'b0, 0, 0);
        // Top-off runs four ticks after termination, then drops
        term <= 1;
        repeat (8) @(posedge mclk_in);
        cmp({31'h0, topoff}, 1, "topoff on");
        repeat (80) @(posedge mclk_in);
        cmp({31'h0, topoff}, 0, "topoff end");
        chg_en_n <= 1;
        boost_req <= 1;
        repeat (8) @(posedge mclk_in);
        // Cold then hot boost faults, each followed by recovery
        for (int j = 0; j < 2; j++) begin
            zone <= 3'(5 + j);
            repeat (10) @(posedge mclk_in);
            cmp({31'h0, boosting}, 0, "boost");
            cmp({29'h0, in_src}, {29'h0, `SRC_STATE_OFF}, "source");
            rd(`FAULT_OFFSET, (5 + j) << 2, 32'h1C);
            zone <= 3'h0;
            repeat (10) @(posedge mclk_in);
            cmp({31'h0, boosting}, 1, "boost");
            rd(`FAULT_OFFSET, 32'h0, 32'h1C);
        end
        depleted <= 1;
        repeat (10) @(posedge mclk_in);
        cmp({31'h0, bat_sw}, 0, "switch");
        finish_test();
    end
endmodule // tb_charge_temp_timer_supervisor
`default_nettype wire
